// ### inc/slt_pkg.sv
// Constants for the synthesizer lock-timeout control block
package slt_pkg;
  localparam int WORD_W = 24;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_GAIN_WORD = 3'h0;
  localparam logic [2:0] ADDR_FEEDBACK_WORD = 3'h1;
  localparam logic [2:0] ADDR_TIMEOUT_WORD = 3'h2;
  localparam logic [2:0] ADDR_IF_REF_WORD = 3'h3;
  localparam int RF_PUMP_GAIN_BIT = 19;
  localparam int RF_PUMP_HIGHZ_BIT = 20;
  localparam int RF_POWERDOWN_BIT = 23;
  localparam int TOC_LSB = 3;
  localparam int TOC_W = 12;
  localparam int IF_DIV_LSB = 3;
  localparam int IF_DIV_W = 15;
  localparam int IF_POLARITY_BIT = 18;
  localparam int IF_PUMP_GAIN_BIT = 19;
  localparam int IF_PUMP_HIGHZ_BIT = 20;
  localparam int IF_COUNTER_RESET_BIT = 21;
  localparam int OUT_SEL_LSB = 22;
  localparam int OUT_SEL_W = 2;
  localparam logic [11:0] TOC_HIGHZ = 12'h000;
  localparam logic [11:0] TOC_MANUAL = 12'h001;
  localparam logic [11:0] TOC_DRIVE_LOW = 12'h002;
  localparam logic [11:0] TOC_DRIVE_HIGH = 12'h003;
  localparam logic [11:0] TOC_AUTO_MIN = 12'h004;
  localparam logic [11:0] TOC_RESET = 12'h000;
  localparam logic [14:0] IF_DIV_RESET = 15'h0003;
  localparam logic [14:0] IF_DIV_MIN = 15'h0003;
endpackage

// ### logic/slt_ref_divider.sv
// Reloading reference divider producing phase-detector events
`timescale 1ns/100ps
module slt_ref_divider #(
  parameter int DIV_W = 15
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic clr,
  input wire logic [DIV_W-1:0] div_value,
  output logic event_pulse
);
  // Width check at elaboration
  if (DIV_W < 2) begin : g_width_check
    $error("slt_ref_divider: DIV_W too small");
  end

  logic [DIV_W-1:0] cnt_q;
  logic ev_q;
  wire terminal = (cnt_q >= div_value - DIV_W'(1));

  // [R13] Count then reload
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      ev_q <= 1'b0;
    end else if (ce) begin
      ev_q <= 1'b0;
      if (clr) begin
        cnt_q <= '0;
      end else if (tick) begin
        cnt_q <= terminal ? '0 : cnt_q + DIV_W'(1);
        ev_q <= terminal;
      end
    end
  end

  assign event_pulse = ev_q;
endmodule

// ### logic/slt_top.sv
// RF lock-timeout control, RF powerdown and IF reference control
`timescale 1ns/100ps
// Function
// [R01] Feedback word bit 23: 0 keeps RF loop active, 1 powers it down.
// [R02] Powerdown bit with pump high-impedance bit selects synchronous or asynchronous mode.
// [R03] Timeout word: address 010 in bits 2:0, value in 14:3, upper zeros.
// [R04] Timeout 4..4095 enables automatic acquisition; 0..3 are fixed pin modes.
// [R05] Timeout 0: pin high impedance, pump gain follows programmed gain bit.
// [R06] Timeout 1: pin driven low, pump forced to high gain.
// [R07] Timeout 2: pin driven low, pump gain follows programmed bit.
// [R08] Timeout 3: pin driven high, pump gain follows programmed bit.
// [R09] Automatic: pin low, high gain for N events, then high impedance, low gain.
// [R10] New timeout value takes effect only at the next phase-detector event.
// [R11] IF reference word holds divider, polarity, gain, high-z, reset, selector bits.
// [R12] Host programs IF divide value only from 3 to 32767.
// [R13] IF reference divider emits one event per programmed count, reloading itself.
module slt_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic word_valid,
  input wire logic [23:0] word_data,
  input wire logic ref_in,
  output logic rf_powerdown,
  output logic rf_powerdown_async,
  output logic rf_pump_highz,
  output logic rf_pump_gain,
  output logic rf_acquire_out_pin,
  output logic rf_acquire_oe_n,
  output logic rf_acquiring,
  output logic if_detector_polarity,
  output logic if_pump_gain,
  output logic if_pump_highz,
  output logic if_counter_reset,
  output logic [1:0] output_selector,
  output logic phase_detector_event
);
  // Reset release through two flops
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Reference pin synchroniser; only the second stage is read
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_prev_q;
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else if (ce) begin
      ref_s1_q <= ref_in;
      ref_s2_q <= ref_s1_q;
      ref_prev_q <= ref_s2_q;
    end
  end
  wire ref_rise = ref_s2_q & ~ref_prev_q;

  // Word decode
  wire [2:0] word_addr = word_data[slt_pkg::ADDR_LSB +: slt_pkg::ADDR_W];
  wire wr_gain = word_valid && (word_addr == slt_pkg::ADDR_GAIN_WORD);
  wire wr_feedback = word_valid && (word_addr == slt_pkg::ADDR_FEEDBACK_WORD);
  // [R03] Timeout word decode
  wire wr_timeout = word_valid && (word_addr == slt_pkg::ADDR_TIMEOUT_WORD);
  // [R11] IF reference word decode
  wire wr_if_ref = word_valid && (word_addr == slt_pkg::ADDR_IF_REF_WORD);
  // Upper timeout-word bits are don't-care here; host keeps them zero
  wire [11:0] new_toc = word_data[slt_pkg::TOC_LSB +: slt_pkg::TOC_W];
  wire [14:0] new_div = word_data[slt_pkg::IF_DIV_LSB +: slt_pkg::IF_DIV_W];

  // Programmed control bits
  logic gain_bit_q;
  logic pump_highz_q;
  logic powerdown_q;
  logic [14:0] if_div_q;
  logic if_pol_q;
  logic if_gain_q;
  logic if_highz_q;
  logic if_rst_q;
  logic [1:0] out_sel_q;
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gain_bit_q <= 1'b0;
      pump_highz_q <= 1'b0;
      powerdown_q <= 1'b0;
      if_div_q <= slt_pkg::IF_DIV_RESET;
      if_pol_q <= 1'b0;
      if_gain_q <= 1'b0;
      if_highz_q <= 1'b0;
      if_rst_q <= 1'b0;
      out_sel_q <= 2'h0;
    end else if (ce) begin
      if (wr_gain) begin
        gain_bit_q <= word_data[slt_pkg::RF_PUMP_GAIN_BIT];
        pump_highz_q <= word_data[slt_pkg::RF_PUMP_HIGHZ_BIT];
      end
      // [R01] Powerdown bit capture
      if (wr_feedback) begin
        powerdown_q <= word_data[slt_pkg::RF_POWERDOWN_BIT];
      end
      // [R11] IF fields capture
      if (wr_if_ref) begin
        // [R12] Values below 3 are clamped, not trusted
        if_div_q <= (new_div < slt_pkg::IF_DIV_MIN) ? slt_pkg::IF_DIV_MIN : new_div;
        if_pol_q <= word_data[slt_pkg::IF_POLARITY_BIT];
        if_gain_q <= word_data[slt_pkg::IF_PUMP_GAIN_BIT];
        if_highz_q <= word_data[slt_pkg::IF_PUMP_HIGHZ_BIT];
        if_rst_q <= word_data[slt_pkg::IF_COUNTER_RESET_BIT];
        out_sel_q <= word_data[slt_pkg::OUT_SEL_LSB +: slt_pkg::OUT_SEL_W];
      end
    end
  end

  // [R13] Reference divider instance
  logic pd_event;
  slt_ref_divider #(
    .DIV_W(slt_pkg::IF_DIV_W)
  ) u_div (
    .clk(clk),
    .rst_n(rst_n_q),
    .ce(ce),
    .tick(ref_rise),
    .clr(if_rst_q),
    .div_value(if_div_q),
    .event_pulse(pd_event)
  );

  // Pending timeout value waits for the next event
  logic [11:0] toc_pend_q;
  logic pend_q;
  logic [11:0] toc_q;
  logic [11:0] acq_cnt_q;
  // Write in the same cycle as an event waits for the following event
  wire latch_now = pd_event && pend_q && !wr_timeout;
  wire auto_mode = (toc_q >= slt_pkg::TOC_AUTO_MIN);
  wire acq_active = auto_mode && (acq_cnt_q != 12'h000);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      toc_pend_q <= slt_pkg::TOC_RESET;
      pend_q <= 1'b0;
      toc_q <= slt_pkg::TOC_RESET;
      acq_cnt_q <= 12'h000;
    end else if (ce) begin
      if (wr_timeout) begin
        toc_pend_q <= new_toc;
        pend_q <= 1'b1;
      end else if (latch_now) begin
        pend_q <= 1'b0;
      end
      // [R10] Latch at event
      if (latch_now) begin
        toc_q <= toc_pend_q;
        acq_cnt_q <= (toc_pend_q >= slt_pkg::TOC_AUTO_MIN) ? toc_pend_q : 12'h000;
      end else if (pd_event && acq_active) begin
        // [R09] Count events down
        acq_cnt_q <= acq_cnt_q - 12'h001;
      end
    end
  end

  // Pin and gain selection
  logic pin_d;
  logic oe_n_d;
  logic gain_d;
  always_comb begin
    pin_d = 1'b0;
    oe_n_d = 1'b1;
    gain_d = gain_bit_q;
    if (auto_mode) begin
      // [R04] Automatic acquisition range
      // [R09] Low and high gain, then high-z and low gain
      oe_n_d = ~acq_active;
      gain_d = acq_active;
    end else begin
      unique case (toc_q)
        // [R05] High impedance
        slt_pkg::TOC_HIGHZ: oe_n_d = 1'b1;
        slt_pkg::TOC_MANUAL: begin
          // [R06] Manual acquisition
          oe_n_d = 1'b0;
          gain_d = 1'b1;
        end
        // [R07] Drive low
        slt_pkg::TOC_DRIVE_LOW: oe_n_d = 1'b0;
        slt_pkg::TOC_DRIVE_HIGH: begin
          // [R08] Drive high
          oe_n_d = 1'b0;
          pin_d = 1'b1;
        end
        default: oe_n_d = 1'b1;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rf_powerdown <= 1'b0;
      rf_powerdown_async <= 1'b0;
      rf_pump_highz <= 1'b0;
      rf_pump_gain <= 1'b0;
      rf_acquire_out_pin <= 1'b0;
      rf_acquire_oe_n <= 1'b1;
      rf_acquiring <= 1'b0;
      if_detector_polarity <= 1'b0;
      if_pump_gain <= 1'b0;
      if_pump_highz <= 1'b0;
      if_counter_reset <= 1'b0;
      output_selector <= 2'h0;
      phase_detector_event <= 1'b0;
    end else if (ce) begin
      // [R01] Loop powerdown
      rf_powerdown <= powerdown_q;
      // [R02] High-z pump selects asynchronous powerdown
      rf_powerdown_async <= powerdown_q & pump_highz_q;
      rf_pump_highz <= pump_highz_q;
      rf_pump_gain <= gain_d;
      rf_acquire_out_pin <= pin_d;
      rf_acquire_oe_n <= oe_n_d;
      rf_acquiring <= acq_active || (toc_q == slt_pkg::TOC_MANUAL);
      if_detector_polarity <= if_pol_q;
      if_pump_gain <= if_gain_q;
      if_pump_highz <= if_highz_q;
      if_counter_reset <= if_rst_q;
      output_selector <= out_sel_q;
      phase_detector_event <= pd_event;
    end
  end
endmodule

// ### tb/slt_properties.sv
// Checker for lock-timeout control outputs
`timescale 1ns/100ps
module slt_checker (
  input logic clk,
  input logic resetn,
  input logic ce,
  input logic word_valid,
  input logic [23:0] word_data,
  input logic rf_powerdown,
  input logic rf_powerdown_async,
  input logic rf_pump_highz,
  input logic rf_pump_gain,
  input logic rf_acquire_out_pin,
  input logic rf_acquire_oe_n,
  input logic rf_acquiring,
  input logic if_counter_reset,
  input logic [1:0] output_selector,
  input logic phase_detector_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire wr = word_valid && ce;
  pd_copy_a: assert property (wr && word_data[2:0] == 3'h1 |-> ##2 rf_powerdown == $past(word_data[23], 2))
    else $error("powerdown copy wrong");
  async_mode_a: assert property (rf_powerdown_async == (rf_powerdown && rf_pump_highz))
    else $error("powerdown mode wrong");
  sel_copy_a: assert property (wr && word_data[2:0] == 3'h3 |-> ##2 output_selector == $past(word_data[23:22], 2))
    else $error("selector copy wrong");
  acq_drive_a: assert property (rf_acquiring |-> rf_pump_gain && !rf_acquire_oe_n && !rf_acquire_out_pin)
    else $error("acquire drive wrong");
  idle_pin_a: assert property (rf_acquire_oe_n |-> !rf_acquiring)
    else $error("idle pin wrong");
  mode_event_a: assert property ($changed(rf_acquire_oe_n) || $changed(rf_acquiring) |-> $past(phase_detector_event))
    else $error("mode change off event");
  event_pulse_a: assert property (phase_detector_event && ce |=> !phase_detector_event)
    else $error("event too long");
  clr_hold_a: assert property (if_counter_reset [*6] |-> !phase_detector_event)
    else $error("event while held");
endmodule
bind slt_top slt_checker chk (
  .clk(clk),
  .resetn(resetn),
  .ce(ce),
  .word_valid(word_valid),
  .word_data(word_data),
  .rf_powerdown(rf_powerdown),
  .rf_powerdown_async(rf_powerdown_async),
  .rf_pump_highz(rf_pump_highz),
  .rf_pump_gain(rf_pump_gain),
  .rf_acquire_out_pin(rf_acquire_out_pin),
  .rf_acquire_oe_n(rf_acquire_oe_n),
  .rf_acquiring(rf_acquiring),
  .if_counter_reset(if_counter_reset),
  .output_selector(output_selector),
  .phase_detector_event(phase_detector_event)
);

// ### tb/slt_host.sv
// Host model: word writer and reference source
`timescale 1ns/100ps
module slt_host (
  input logic clk,
  output logic word_valid = 1'b0,
  output logic [23:0] word_data = 24'h000000,
  output logic ref_in = 1'b0
);
  logic run = 1'b0;
  logic ph = 1'b0;
  // Levels held two clocks for the synchroniser
  always @(posedge clk) begin
    ph <= run ? ~ph : ph;
    if (run && ph) ref_in <= ~ref_in;
  end
  // Zero upper timeout bits, divide 3 or more
  task automatic put(input logic [2:0] a, input logic [20:0] d);
    if (a == 3'h2) d[20:12] = 9'h000;
    if (a == 3'h3 && d[14:0] < 15'h0003) d[14:0] = 15'h0003;
    @(posedge clk);
    word_valid <= 1'b1;
    word_data <= {d, a};
    @(posedge clk);
    word_valid <= 1'b0;
    word_data <= ~{d, a};
  endtask
endmodule

// ### tb/test_synth_lock_timeout_control.sv
// Testbench for the lock-timeout control block
`timescale 1ns/100ps
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module test_synth_lock_timeout_control;
  logic clk = 0, resetn = 0, ce = 1, probe = 0;
  int n_mismatch = 0, checks = 0, k;
  logic [31:0] r;
  logic [3:0] acq = 4'h8;
  logic pd = 0, hz = 0;
  logic [5:0] ifb = 0;
  logic [12:0] q[$], e;
  logic [3:0] tab [4] = '{4'h8, 4'h3, 4'h0, 4'h4};
  wire word_valid, ref_in, rf_powerdown, rf_powerdown_async, rf_pump_highz, rf_pump_gain;
  wire rf_acquire_out_pin, rf_acquire_oe_n, rf_acquiring, if_detector_polarity, if_pump_gain;
  wire if_pump_highz, if_counter_reset, phase_detector_event;
  wire [23:0] word_data;
  wire [1:0] output_selector;
  wire [12:0] obs = {rf_acquire_oe_n, rf_acquire_out_pin, rf_pump_gain, rf_acquiring, rf_powerdown,
    rf_powerdown_async, rf_pump_highz, output_selector,
    if_detector_polarity, if_pump_gain, if_pump_highz, if_counter_reset};
  slt_top dut (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .word_valid(word_valid),
    .word_data(word_data),
    .ref_in(ref_in),
    .rf_powerdown(rf_powerdown),
    .rf_powerdown_async(rf_powerdown_async),
    .rf_pump_highz(rf_pump_highz),
    .rf_pump_gain(rf_pump_gain),
    .rf_acquire_out_pin(rf_acquire_out_pin),
    .rf_acquire_oe_n(rf_acquire_oe_n),
    .rf_acquiring(rf_acquiring),
    .if_detector_polarity(if_detector_polarity),
    .if_pump_gain(if_pump_gain),
    .if_pump_highz(if_pump_highz),
    .if_counter_reset(if_counter_reset),
    .output_selector(output_selector),
    .phase_detector_event(phase_detector_event)
  );
  slt_host host (
    .clk(clk),
    .word_valid(word_valid),
    .word_data(word_data),
    .ref_in(ref_in)
  );
  initial forever #10 clk = ~clk;
  task automatic note;
    q.push_back({acq, pd, pd & hz, hz, ifb});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask
  // Bounded wait so a dead divider cannot hang the run
  task automatic sync;
    k = 0;
    do @(posedge clk); while (phase_detector_event !== 1'b1 && ++k < 60);
    if (k == 60) n_mismatch++;
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    if (probe) begin
      e = q.pop_front();
      `CMP(obs, e)
    end
  end
  initial begin
    #50us;
    n_mismatch++;
    conclude();
  end
  initial begin
    r = $urandom(32'hca2fa5d0);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    note();
    host.run <= 1'b1;
    r = $urandom;
    ifb = {r[1:0], r[2], r[3], r[4], 1'b0};
    host.put(3'h3, {r[1:0], 1'b0, r[4:2], 15'h0003});
    repeat (2) @(posedge clk);
    note();
    hz = 1'b1;
    pd = 1'b1;
    host.put(3'h0, 21'h020000);
    host.put(3'h1, 21'h100000);
    repeat (2) @(posedge clk);
    note();
    pd = 1'b0;
    host.put(3'h1, 21'h000000);
    repeat (2) @(posedge clk);
    note();
    for (int v = 3; v >= 0; v--) begin
      sync();
      host.put(3'h2, 21'(v));
      note();
      repeat (2) @(posedge clk);
      sync();
      acq = tab[v];
      note();
    end
    acq = 4'ha;
    host.put(3'h0, 21'h030000);
    repeat (2) @(posedge clk);
    note();
    sync();
    host.put(3'h2, 21'h000004);
    repeat (2) @(posedge clk);
    sync();
    acq = 4'h3;
    note();
    repeat (3) sync();
    note();
    sync();
    acq = 4'h8;
    note();
    // Frozen block ignores a word and holds every output
    ce <= 1'b0;
    host.put(3'h1, 21'h100000);
    repeat (4) @(posedge clk);
    note();
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    note();
    ifb[0] = 1'b1;
    host.put(3'h3, {ifb[5:4], 1'b1, ifb[1], ifb[2], ifb[3], 15'h0003});
    repeat (30) @(posedge clk);
    note();
    conclude();
  end
endmodule
